//--- rtl/sar_host_ctrl.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "sar_port_defs.svh"
module sar_host_ctrl (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic RES_VALID,
    output logic [17:0] RES_DATA,
    input wire logic RES_READY,
    sar_link_if.host LNK
);
    // ***********************************************************
    // State
    // ***********************************************************
    sar_port_pkg::host_s st_ff;
    sar_port_pkg::host_s nxt_st;
    logic [1:0] fmt;
    logic [1:0] last_part;
    logic sclk_rise;

    assign fmt = st_ff.ctrl[`CTRL_FMT+:2];
    assign last_part = (fmt == `FMT_B8) ? 2'd2 : ((fmt == `FMT_W16) ? 2'd1 : 2'd0);
    assign sclk_rise = LNK.ser_clk & ~st_ff.sclk_prev;

    // ***********************************************************
    // Registers, sequencer, result buffer
    // ***********************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_prev = LNK.ser_clk;
        // Zero-wait APB: answer prepared in setup, ready in access
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            nxt_st.pready = 1'b1;
            case (PADDR)
                `REG_CTRL: nxt_st.prdata = {26'h0, st_ff.ctrl};
                `REG_STATUS: nxt_st.prdata = {26'h0, st_ff.tail_v, st_ff.head_v,
                    LNK.busy, st_ff.state};
                `REG_RESULT: nxt_st.prdata = {14'h0, st_ff.last};
                default: begin
                    nxt_st.prdata = 32'h0;
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        if (PSEL && PENABLE && st_ff.pready && PWRITE && PADDR == `REG_CTRL) begin
            nxt_st.ctrl = PWDATA[5:0];
        end
        // Drain side of the two-entry buffer
        if (RES_READY && st_ff.head_v) begin
            nxt_st.head = st_ff.tail;
            nxt_st.head_v = st_ff.tail_v;
            nxt_st.tail_v = 1'b0;
        end
        if (st_ff.gap != 8'h00) begin
            nxt_st.gap = st_ff.gap - 8'h01;
        end
        case (st_ff.state)
            // start spacing; full buffer stalls conversions
            sar_port_pkg::H_IDLE: begin
                if (st_ff.ctrl[`CTRL_RUN] && !st_ff.ctrl[`CTRL_PD] && !st_ff.ctrl[`CTRL_RST]
                    && !st_ff.tail_v && st_ff.gap == 8'h00 && !LNK.busy) begin
                    nxt_st.cnv_n = 1'b0;
                    nxt_st.wait_cnt = 8'(`CNV_LOW_CYC - 1);
                    nxt_st.gap = 8'(`RATE_CYC - 1);
                    nxt_st.state = sar_port_pkg::H_START;
                end
            end
            sar_port_pkg::H_START: begin
                if (st_ff.wait_cnt != 8'h00) begin
                    nxt_st.wait_cnt = st_ff.wait_cnt - 8'h01;
                end else begin
                    nxt_st.cnv_n = 1'b1;
                    nxt_st.state = sar_port_pkg::H_WAIT_HI;
                end
            end
            sar_port_pkg::H_WAIT_HI: begin
                if (LNK.busy) begin
                    nxt_st.state = sar_port_pkg::H_WAIT_LO;
                end
            end
            // select and read low for the whole read
            sar_port_pkg::H_WAIT_LO: begin
                if (!LNK.busy) begin
                    nxt_st.cs_n = 1'b0;
                    nxt_st.rd_n = 1'b0;
                    nxt_st.part = 2'd0;
                    nxt_st.sbits = 5'd0;
                    nxt_st.word = '0;
                    nxt_st.wait_cnt = 8'(`RD_SETTLE_CYC - 1);
                    nxt_st.state = sar_port_pkg::H_READ;
                end
            end
            sar_port_pkg::H_READ: begin
                if (fmt == `FMT_SER) begin
                    if (sclk_rise) begin
                        nxt_st.word = {st_ff.word[16:0], LNK.ser_data};
                        nxt_st.sbits = st_ff.sbits + 5'd1;
                        if (st_ff.sbits == `SER_BITS - 5'd1) begin
                            nxt_st.cs_n = 1'b1;
                            nxt_st.rd_n = 1'b1;
                            nxt_st.state = sar_port_pkg::H_PUSH;
                        end
                    end
                end else if (st_ff.wait_cnt != 8'h00) begin
                    nxt_st.wait_cnt = st_ff.wait_cnt - 8'h01;
                end else begin
                    case ({fmt, st_ff.part})
                        {`FMT_W16, 2'd0}: nxt_st.word[17:2] = LNK.line[17:2];
                        {`FMT_W16, 2'd1}: nxt_st.word[1:0] = {LNK.line[3], LNK.line[2]};
                        {`FMT_B8, 2'd0}: nxt_st.word[17:10] = LNK.line[17:10];
                        {`FMT_B8, 2'd1}: nxt_st.word[9:2] = LNK.line[17:10];
                        {`FMT_B8, 2'd2}: nxt_st.word[1:0] = {LNK.line[11], LNK.line[10]};
                        default: nxt_st.word = LNK.line;
                    endcase
                    nxt_st.wait_cnt = 8'(`RD_SETTLE_CYC - 1);
                    nxt_st.part = st_ff.part + 2'd1;
                    if (st_ff.part == last_part) begin
                        nxt_st.cs_n = 1'b1;
                        nxt_st.rd_n = 1'b1;
                        nxt_st.part = 2'd0;
                        nxt_st.state = sar_port_pkg::H_PUSH;
                    end
                end
            end
            sar_port_pkg::H_PUSH: begin
                nxt_st.last = st_ff.word;
                if (!nxt_st.head_v) begin
                    nxt_st.head = st_ff.word;
                    nxt_st.head_v = 1'b1;
                end else begin
                    nxt_st.tail = st_ff.word;
                    nxt_st.tail_v = 1'b1;
                end
                nxt_st.state = sar_port_pkg::H_IDLE;
            end
            default: nxt_st.state = sar_port_pkg::H_IDLE;
        endcase
        nxt_st.h_out = '0;
        nxt_st.h_oe = '0;
        nxt_st.h_out[`LINE_CODING] = nxt_st.ctrl[`CTRL_CODING];
        nxt_st.h_oe[`LINE_CODING] = nxt_st.ctrl[`CTRL_FMT+:2] != `FMT_PAR18;
        nxt_st.h_oe[`LINE_WSEL] = nxt_st.ctrl[`CTRL_FMT+:2] == `FMT_W16 ||
            nxt_st.ctrl[`CTRL_FMT+:2] == `FMT_B8;
        nxt_st.h_oe[`LINE_BSEL] = nxt_st.ctrl[`CTRL_FMT+:2] == `FMT_B8;
        nxt_st.h_out[`LINE_WSEL] = (nxt_st.ctrl[`CTRL_FMT+:2] == `FMT_B8) ?
            nxt_st.part[1] : nxt_st.part[0];
        nxt_st.h_out[`LINE_BSEL] = nxt_st.part[0];
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_ff <= '0;
            st_ff.ctrl <= `CTRL_RST_VAL;
            st_ff.cnv_n <= 1'b1;
            st_ff.cs_n <= 1'b1;
            st_ff.rd_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ***********************************************************
    // Port drive, all from flip-flops
    // ***********************************************************
    assign PRDATA = st_ff.prdata;
    assign PREADY = st_ff.pready;
    assign PSLVERR = st_ff.pslverr;
    assign RES_VALID = st_ff.head_v;
    assign RES_DATA = st_ff.head;
    // start only after prior read, acquisition elapsed
    assign LNK.conv_start_n = st_ff.cnv_n;
    assign LNK.cs_n = st_ff.cs_n;
    assign LNK.rd_n = st_ff.rd_n;
    assign LNK.adc_reset = st_ff.ctrl[`CTRL_RST];
    assign LNK.powerdown_in = st_ff.ctrl[`CTRL_PD];
    assign LNK.bus_format_sel0 = st_ff.ctrl[`CTRL_FMT];
    assign LNK.bus_format_sel1 = st_ff.ctrl[`CTRL_FMT+1];
    assign LNK.host_out = st_ff.h_out;
    assign LNK.host_oe = st_ff.h_oe;
endmodule // sar_host_ctrl

//--- rtl/sar_port_defs.svh
`ifndef SAR_PORT_DEFS_SVH
`define SAR_PORT_DEFS_SVH
// ***********************************************************
// Result and coding
// ***********************************************************
`define RES_W 18
`define MIDSCALE 18'h20000
`define MSB_MASK 18'h20000
// ***********************************************************
// Timing, figures in ns, counts in 20 ns cycles
// ***********************************************************
`define CLK_NS 20
`define T_BIT_NS 40
`define BIT_CYC ((`T_BIT_NS + `CLK_NS - 1) / `CLK_NS)
`define T_ACQ_NS 60
`define ACQ_CYC ((`T_ACQ_NS + `CLK_NS - 1) / `CLK_NS)
`define T_CAL_NS 400
`define CAL_CYC ((`T_CAL_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RATE_NS 800
`define RATE_CYC ((`T_RATE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_CNV_LOW_NS 40
`define CNV_LOW_CYC ((`T_CNV_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_SETTLE_CYC 3
`define SER_BITS 5'd18
// ***********************************************************
// Bus formats and dual-use lines
// ***********************************************************
`define FMT_PAR18 2'b00
`define FMT_W16 2'b01
`define FMT_B8 2'b10
`define FMT_SER 2'b11
`define LINE_CODING 0
`define LINE_WSEL 1
`define LINE_BSEL 2
// ***********************************************************
// Controller registers
// ***********************************************************
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RESULT 12'h008
`define CTRL_RUN 0
`define CTRL_CODING 1
`define CTRL_FMT 2
`define CTRL_PD 4
`define CTRL_RST 5
`define CTRL_RST_VAL 6'h02
`endif

//--- rtl/sar_port_pkg.sv
`include "sar_port_defs.svh"
package sar_port_pkg;
    typedef enum logic [1:0] {DEV_IDLE = 2'b00, DEV_CONV = 2'b01, DEV_CAL = 2'b11} dev_state_e;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_START = 3'b001, H_WAIT_HI = 3'b011,
        H_WAIT_LO = 3'b010, H_READ = 3'b110, H_PUSH = 3'b111
    } host_state_e;
    typedef logic [`RES_W-1:0] word_t;
    typedef struct packed {
        dev_state_e state;
        logic busy;
        logic signed [19:0] hold;
        word_t trial;
        word_t mask;
        word_t result;
        logic [7:0] div;
        logic [7:0] acq;
        logic [7:0] cal;
        logic rst_prev;
        logic cnv_prev;
        word_t d_out;
        word_t d_oe;
        word_t sh;
        logic [4:0] scnt;
        logic sph;
        logic sclk;
        logic sdat;
        logic soe;
    } dev_s;
    typedef struct packed {
        host_state_e state;
        logic [5:0] ctrl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cnv_n;
        logic cs_n;
        logic rd_n;
        word_t h_out;
        word_t h_oe;
        logic [1:0] part;
        logic [7:0] wait_cnt;
        logic [7:0] gap;
        word_t word;
        logic sclk_prev;
        logic [4:0] sbits;
        word_t head;
        logic head_v;
        word_t tail;
        logic tail_v;
        word_t last;
    } host_s;
endpackage

//--- rtl/sar_link_if.sv
`timescale 1ns/10ps
interface sar_link_if;
    logic conv_start_n;
    logic cs_n;
    logic rd_n;
    logic adc_reset;
    logic powerdown_in;
    logic bus_format_sel0;
    logic bus_format_sel1;
    logic busy;
    logic [17:0] dev_out;
    logic [17:0] dev_oe;
    logic [17:0] host_out;
    logic [17:0] host_oe;
    logic [17:0] line;
    logic ser_clk;
    logic ser_data;
    logic ser_oe;
    // Wire level of the shared lines; an undriven line reads low
    assign line = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out);
    modport dev (
        input conv_start_n, cs_n, rd_n, adc_reset, powerdown_in,
        input bus_format_sel0, bus_format_sel1, line,
        output busy, dev_out, dev_oe, ser_clk, ser_data, ser_oe
    );
    modport host (
        output conv_start_n, cs_n, rd_n, adc_reset, powerdown_in,
        output bus_format_sel0, bus_format_sel1, host_out, host_oe,
        input busy, line, ser_clk, ser_data, ser_oe
    );
endinterface

//--- rtl/sar_conv_dev.sv
`timescale 1ns/10ps
`include "sar_port_defs.svh"
// Behaviour
// - Two pins pick parallel, word, byte, serial
// - Word mode: line 1 selects high/low word
// - Byte mode: lines 1,2 select one byte
// - Line 0 selects coding outside 18-bit mode
// - Zero input gives midscale or zero code
// - Twos complement is binary with MSB inverted
// - Overrange saturates at full-scale code
// - Underrange saturates at minimum code
// - Start needs finished acquisition and low start
// - Successive approximation, MSB first, 18 steps
// - Form code, then drop busy
// - Result belongs to the latest conversion
// - Starts sustained up to 1.25 MHz
// - Bus driven only with select and read low
// - Reset aborts; its release pulses busy
// - Power-down finishes current, refuses new starts
// - Start falling edge holds sample, launches
module sar_conv_dev (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic signed [19:0] ANALOG_IN,
    sar_link_if.dev LNK
);
    // ***********************************************************
    // State and decoded inputs
    // ***********************************************************
    sar_port_pkg::dev_s st_ff;
    sar_port_pkg::dev_s nxt_st;
    logic [1:0] fmt;
    logic bus_en;
    logic cnv_fall;
    logic rst_fall;
    logic keep_bit;
    logic signed [20:0] target;
    sar_port_pkg::word_t trial_bit;
    sar_port_pkg::word_t coded;
    sar_port_pkg::word_t lines;
    sar_port_pkg::word_t oes;

    assign fmt = {LNK.bus_format_sel1, LNK.bus_format_sel0};
    assign bus_en = ~LNK.cs_n & ~LNK.rd_n;
    assign cnv_fall = st_ff.cnv_prev & ~LNK.conv_start_n;
    assign rst_fall = st_ff.rst_prev & ~LNK.adc_reset;

    // Held input shifted to offset binary; the compare itself clamps
    // saturation by compare
    assign target = 21'(st_ff.hold) + 21'sh20000;
    assign trial_bit = st_ff.trial | st_ff.mask;
    assign keep_bit = target >= $signed({3'b000, trial_bit});

    assign coded = (fmt == `FMT_PAR18 || LNK.line[`LINE_CODING]) ? st_ff.result :
        (st_ff.result ^ `MSB_MASK);

    // ***********************************************************
    // Parallel line mapping
    // ***********************************************************
    always_comb begin
        lines = '0;
        oes = '0;
        case (fmt)
            `FMT_PAR18: begin
                lines = coded;
                oes = '1;
            end
            `FMT_W16: begin
                oes = 18'h3fffc;
                if (!LNK.line[`LINE_WSEL]) begin
                    lines = {coded[17:2], 2'b00};
                end else begin
                    lines[2] = coded[0];
                    lines[3] = coded[1];
                end
            end
            `FMT_B8: begin
                oes = 18'h3fc00;
                case ({LNK.line[`LINE_WSEL], LNK.line[`LINE_BSEL]})
                    2'b00: lines[17:10] = coded[17:10];
                    2'b01: lines[17:10] = coded[9:2];
                    2'b10: lines[11:10] = {coded[1], coded[0]};
                    default: lines[17:16] = {coded[1], coded[0]};
                endcase
            end
            default: begin
                lines = '0;
                oes = '0;
            end
        endcase
    end

    // ***********************************************************
    // Conversion control, output drive, serial shifter
    // ***********************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_prev = LNK.adc_reset;
        nxt_st.cnv_prev = LNK.conv_start_n;
        if (st_ff.acq != 8'h00) begin
            nxt_st.acq = st_ff.acq - 8'h01;
        end
        case (st_ff.state)
            sar_port_pkg::DEV_IDLE: begin
                if (cnv_fall && !LNK.powerdown_in && st_ff.acq == 8'h00) begin
                    nxt_st.state = sar_port_pkg::DEV_CONV;
                    nxt_st.busy = 1'b1;
                    nxt_st.hold = ANALOG_IN;
                    nxt_st.trial = '0;
                    nxt_st.mask = `MSB_MASK;
                    nxt_st.div = 8'(`BIT_CYC - 1);
                end
            end
            sar_port_pkg::DEV_CONV: begin
                if (st_ff.div != 8'h00) begin
                    nxt_st.div = st_ff.div - 8'h01;
                end else begin
                    if (keep_bit) begin
                        nxt_st.trial = trial_bit;
                    end
                    nxt_st.mask = st_ff.mask >> 1;
                    nxt_st.div = 8'(`BIT_CYC - 1);
                    if (st_ff.mask[0]) begin
                        nxt_st.result = keep_bit ? trial_bit : st_ff.trial;
                        nxt_st.busy = 1'b0;
                        nxt_st.state = sar_port_pkg::DEV_IDLE;
                        nxt_st.acq = 8'(`ACQ_CYC);
                    end
                end
            end
            sar_port_pkg::DEV_CAL: begin
                if (st_ff.cal != 8'h00) begin
                    nxt_st.cal = st_ff.cal - 8'h01;
                end else begin
                    nxt_st.busy = 1'b0;
                    nxt_st.state = sar_port_pkg::DEV_IDLE;
                end
            end
            default: begin
                nxt_st.state = sar_port_pkg::DEV_IDLE;
                nxt_st.busy = 1'b0;
            end
        endcase
        if (LNK.adc_reset) begin
            nxt_st.state = sar_port_pkg::DEV_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.acq = 8'h00;
        end else if (rst_fall) begin
            nxt_st.state = sar_port_pkg::DEV_CAL;
            nxt_st.busy = 1'b1;
            nxt_st.cal = 8'(`CAL_CYC - 1);
        end
        nxt_st.d_out = bus_en ? lines : '0;
        nxt_st.d_oe = bus_en ? oes : '0;
        // serial: MSB first, clock high when data settled
        if (bus_en && fmt == `FMT_SER) begin
            if (!st_ff.soe) begin
                nxt_st.soe = 1'b1;
                nxt_st.sh = coded;
                nxt_st.sdat = coded[17];
                nxt_st.scnt = 5'd0;
                nxt_st.sph = 1'b0;
                nxt_st.sclk = 1'b0;
            end else if (st_ff.scnt != `SER_BITS) begin
                if (!st_ff.sph) begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.sph = 1'b1;
                end else begin
                    nxt_st.sclk = 1'b0;
                    nxt_st.sph = 1'b0;
                    nxt_st.sh = st_ff.sh << 1;
                    nxt_st.sdat = st_ff.sh[16];
                    nxt_st.scnt = st_ff.scnt + 5'd1;
                end
            end
        end else begin
            nxt_st.soe = 1'b0;
            nxt_st.sclk = 1'b0;
            nxt_st.sdat = 1'b0;
        end
    end

    // Start edge detector resets high so a low pin at release counts as a start
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_ff <= '0;
            st_ff.cnv_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ***********************************************************
    // Pin drive, all from flip-flops
    // ***********************************************************
    assign LNK.busy = st_ff.busy;
    assign LNK.dev_out = st_ff.d_out;
    assign LNK.dev_oe = st_ff.d_oe;
    assign LNK.ser_clk = st_ff.sclk;
    assign LNK.ser_data = st_ff.sdat;
    assign LNK.ser_oe = st_ff.soe;
endmodule // sar_conv_dev

//--- verification/sar_port_assertions.sv
`timescale 1ns/10ps
// ****************************************
// Link checker
// ****************************************
module sar_port_assertions (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic conv_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic adc_reset,
    input wire logic powerdown_in,
    input wire logic bus_format_sel0,
    input wire logic bus_format_sel1,
    input wire logic busy,
    input wire logic [17:0] dev_oe,
    input wire logic ser_clk,
    input wire logic ser_oe
);
    logic sel_ff;
    logic [1:0] fmt_ff;
    logic [1:0] fmt;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    assign fmt = {bus_format_sel1, bus_format_sel0};
    // Outputs are registered, so they trail select and format by a cycle
    always_ff @(posedge CORE_CLK) begin
        sel_ff <= !cs_n && !rd_n;
        fmt_ff <= fmt;
    end
    AST_OE_SEL: assert property ((|dev_oe) || ser_oe |-> sel_ff)
        else $error("bus driven unselected");
    AST_SER_HIZ: assert property (fmt_ff == 2'b11 && fmt == 2'b11 |-> dev_oe == 18'h0)
        else $error("lines driven in serial");
    AST_BYTE_HIZ: assert property (fmt_ff == 2'b10 && fmt == 2'b10 |-> dev_oe[9:0] == 10'h0)
        else $error("low lines driven in byte");
    AST_WORD_IN: assert property (fmt_ff == 2'b01 && fmt == 2'b01 |-> dev_oe[1:0] == 2'h0)
        else $error("select lines driven in word");
    AST_BUSY_MIN: assert property (disable iff (SYS_RST || adc_reset)
        $rose(busy) |-> busy[*8]) else $error("busy too short");
    AST_BUSY_END: assert property (disable iff (SYS_RST || adc_reset)
        $rose(busy) |-> ##[18:38] !busy) else $error("busy too long");
    AST_RST_IDLE: assert property (adc_reset && $past(adc_reset) |-> !busy)
        else $error("busy in reset");
    AST_PD_HOLD: assert property (powerdown_in && !busy && !adc_reset && !$past(adc_reset)
        |=> !busy) else $error("start in power-down");
    AST_SER_CLK: assert property (ser_clk |=> !ser_clk)
        else $error("serial clock stuck");
    // Host spacing keeps acquisition done, so an idle start must take
    AST_START_BUSY: assert property ($fell(conv_start_n) && !busy && !powerdown_in
        && !adc_reset |=> busy) else $error("start not taken");
    cover property ($fell(busy));
    cover property (fmt == 2'b11 && ser_clk);
    cover property (fmt == 2'b10 && (|dev_oe));
endmodule // sar_port_assertions

//--- verification/sar_adc_conversion_output_port_test.sv
`timescale 1ns/10ps
// ****************************************
// Host and device face to face
// ****************************************
module sar_adc_conversion_output_port_test;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic signed [19:0] analog_in = 20'sh0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic res_valid;
    logic [17:0] res_data;
    logic res_ready = 1'b0;
    logic [31:0] rd;
    logic err;
    integer seed = 76;
    integer n_mismatch = 0;
    integer checked = 0;
    sar_link_if link ();
    sar_conv_dev sar_conv_dev_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .ANALOG_IN(analog_in), .LNK(link));
    sar_host_ctrl sar_host_ctrl_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RES_VALID(res_valid), .RES_DATA(res_data),
        .RES_READY(res_ready), .LNK(link));
    sar_port_assertions sar_port_assertions_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .conv_start_n(link.conv_start_n),
        .cs_n(link.cs_n), .rd_n(link.rd_n), .adc_reset(link.adc_reset),
        .powerdown_in(link.powerdown_in), .bus_format_sel0(link.bus_format_sel0),
        .bus_format_sel1(link.bus_format_sel1), .busy(link.busy), .dev_oe(link.dev_oe),
        .ser_clk(link.ser_clk), .ser_oe(link.ser_oe));
    // Free running clock, 20 ns period
    initial forever #10 core_clk = ~core_clk;
    // Expected code: clamp to the 18-bit range, twos complement flips the top bit
    function automatic logic [17:0] code_of(input logic signed [19:0] v, input logic bin);
        logic signed [20:0] s;
        logic [17:0] c;
        s = v + 21'sd131072;
        c = s < 0 ? 18'h0 : (s > 21'sd262143 ? 18'h3ffff : s[17:0]);
        return bin ? c : c ^ 18'h20000;
    endfunction
    task automatic summarize();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic timeout_hit();
        n_mismatch++;
        $display("CHECK FAILED wait expected done seen timeout");
        summarize();
    endtask
    task automatic cmp_word(input string what, input logic [17:0] e, input logic [17:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        // Ready, data and error are all taken at the rising edge itself
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            if (++i > 50) timeout_hit();
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Accept one result with a randomly stalling consumer
    task automatic take(input logic [17:0] e);
        integer i;
        for (i = 0; i < 2000; i++) begin
            @(negedge core_clk);
            if (res_valid === 1'b1 && res_ready === 1'b1) break;
            @(posedge core_clk);
            res_ready <= 1'($random(seed));
        end
        if (i >= 2000) timeout_hit();
        cmp_word("result", e, res_data);
        @(posedge core_clk);
        res_ready <= 1'b0;
    endtask
    initial begin
        logic signed [19:0] corner [5];
        logic signed [19:0] v;
        logic [17:0] e;
        logic [31:0] ctl;
        integer k;
        integer i;
        corner = '{20'sd0, 20'sd1, 20'sd200000, -20'sd200000, -20'sd1};
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        cmp_reg("ctrl reset", 32'h2, rd);
        apb(1'b0, 12'h00c, 32'h0);
        cmp_reg("unmapped error", 32'h1, {31'h0, err});
        ctl = 32'h2;
        e = 18'h0;
        // Every format and coding over corner and random inputs
        for (k = 0; k < 26; k++) begin
            apb(1'b1, 12'h000, ctl & ~32'h1);
            res_ready <= 1'b1;
            rd = 32'h3f;
            for (i = 0; rd[5:0] !== 6'h0; i++) begin
                if (i > 200) timeout_hit();
                apb(1'b0, 12'h004, 32'h0);
            end
            res_ready <= 1'b0;
            apb(1'b0, 12'h008, 32'h0);
            if (k > 0) cmp_reg("result reg", {14'h0, e}, rd);
            v = k < 20 ? corner[k % 5] : 20'($random(seed) % 140000);
            analog_in <= v;
            ctl = {28'h0, k[1:0], k[2], 1'b1};
            apb(1'b1, 12'h000, ctl);
            e = code_of(v, k[2] || k[1:0] == 2'b00);
            take(e);
            take(e);
        end
        // Stall until both entries fill, then drain without loss
        rd = 32'h0;
        for (i = 0; rd[5:4] !== 2'b11; i++) begin
            if (i > 300) timeout_hit();
            apb(1'b0, 12'h004, 32'h0);
        end
        take(e);
        take(e);
        // Power-down, then an abort and the calibration pulse
        apb(1'b1, 12'h000, ctl | 32'h10);
        apb(1'b1, 12'h000, ctl | 32'h20);
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        cmp_reg("calibration busy", 32'h1, {31'h0, rd[3]});
        summarize();
    end
endmodule // sar_adc_conversion_output_port_test
